// file: lsag_core.sv
// load/store address generation, decode and load-data formatting
//
// Notes on behaviour
// RULE1: T with post-index gives user access
// RULE2: software never sets T with pre-index
// RULE3: byte bit picks byte, else word
// RULE4: pc base: offset pre-corrected, no write-back
// RULE5: offset register shifted by immediate amount
// RULE6: write-back flag stores address into base
// RULE7: pre-index register write-back uses sum
// RULE8: post-index: old base addresses, sum written
// RULE9: pre-index without write-back leaves base
// RULE10: left shift by two scales index
// RULE11: byte load zero-extends into bits 7:0
// RULE12: failed condition has no effect
// RULE13: label access encoded pc-relative by tools
// RULE14: pc base reads instruction address plus 8
// RULE15: post-index always writes base back (here not when the base is pc)
// RULE16: byte store repeats low byte four times
// RULE17: up bit adds, else subtracts offset
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module lsag_core
  import lsag_pkg::*;
(
  input  wire logic        SYS_CLK,     // core clock, 250 MHz
  input  wire logic        RST,         // asynchronous reset, high
  input  wire logic        ISSUE,       // instruction presented
  input  wire logic [31:0] INSTR,       // instruction word
  input  wire logic [31:0] INSTR_ADDR,  // address of that instruction
  input  wire logic [3:0]  FLAGS,       // current N Z C V
  input  wire logic [31:0] BASE_VAL,    // base_reg contents
  input  wire logic [31:0] INDEX_VAL,   // index_reg contents
  input  wire logic [31:0] SRC_VAL,     // store source contents
  input  wire logic        MEM_DONE,    // memory finished the transfer
  input  wire logic [31:0] MEM_RDATA,   // load data from the bus
  output logic             BUSY,        // transfer in flight
  output logic             MEM_REQ,     // memory request valid
  output logic             MEM_WRITE,   // 1 store, 0 load
  output logic             MEM_BYTE,    // 1 byte, 0 word
  output logic             MEM_USER,    // non-privileged transfer
  output logic [31:0]      MEM_ADDR,    // transfer address
  output logic [31:0]      MEM_WDATA,   // store data
  output logic             BASE_WE,     // base write-back pulse
  output logic [3:0]       BASE_NUM,    // base register number
  output logic [31:0]      BASE_NEW,    // new base value
  output logic             DEST_WE,     // load result pulse
  output logic [3:0]       DEST_NUM,    // destination number
  output logic [31:0]      DEST_DATA    // load result
);

  lsag_state_t q;  // registered state
  lsag_state_t d;  // next state

  // condition check against the NZCV flags
  function automatic logic cond_ok(input logic [3:0] c,
                                   input logic [3:0] f);
    logic r;
    r = 1'b0;
    case (c)
      CC_EQ:   r = f[FL_Z];
      CC_NE:   r = !f[FL_Z];
      CC_CS:   r = f[FL_C];
      CC_CC:   r = !f[FL_C];
      CC_MI:   r = f[FL_N];
      CC_PL:   r = !f[FL_N];
      CC_VS:   r = f[FL_V];
      CC_VC:   r = !f[FL_V];
      CC_HI:   r = f[FL_C] && !f[FL_Z];
      CC_LS:   r = !f[FL_C] || f[FL_Z];
      CC_GE:   r = f[FL_N] == f[FL_V];
      CC_LT:   r = f[FL_N] != f[FL_V];
      CC_GT:   r = !f[FL_Z] && (f[FL_N] == f[FL_V]);
      CC_LE:   r = f[FL_Z] || (f[FL_N] != f[FL_V]);
      CC_AL:   r = 1'b1;
      default: r = 1'b0;  // never code: no effect
    endcase
    return r;
  endfunction : cond_ok

  // immediate shift of the index register; amount 0 has special forms
  function automatic logic [31:0] shift_imm(input logic [31:0] v,
                                            input logic [1:0]  t,
                                            input logic [4:0]  a,
                                            input logic        cin);
    logic [31:0] r;
    r = v;
    case (t)
      SH_LSL: r = v << a;
      SH_LSR: r = (a == 5'h0) ? 32'h0000_0000 : (v >> a);
      SH_ASR: r = (a == 5'h0) ? {32{v[31]}}
                              : 32'($signed(v) >>> a);
      SH_ROR: r = (a == 5'h0) ? {cin, v[31:1]}
                              : ((v >> a) | (v << (6'd32 - {1'b0, a})));
      default: r = v;
    endcase
    return r;
  endfunction : shift_imm

  // pick one byte lane of a word
  function automatic logic [7:0] lane_of(input logic [31:0] w,
                                         input logic [1:0]  l);
    return w[l*BYTE_W +: BYTE_W];
  endfunction : lane_of

  // decoded fields
  logic        is_sdt;
  logic        pre, up, bsz, wb, ld, immf;
  logic [3:0]  rn, rd;
  logic [31:0] base_eff;  // base as read, pc adjusted
  logic [31:0] offset;    // unsigned offset magnitude
  logic [31:0] sum;       // base +/- offset
  logic        exec;      // condition holds
  // write-back intent kept from issue; INSTR may change while busy
  logic        wb_q;
  logic        pre_q;

  always_comb begin
    is_sdt = INSTR[CLASS_HI:CLASS_LO] == CLASS_SDT;
    immf   = INSTR[IMM_BIT];
    pre    = INSTR[PRE_BIT];
    up     = INSTR[UP_BIT];
    bsz    = INSTR[BYTE_BIT];
    wb     = INSTR[WB_BIT];
    ld     = INSTR[LOAD_BIT];
    rn     = INSTR[RN_HI:RN_LO];
    rd     = INSTR[RD_HI:RD_LO];
    // RULE14: pc reads ahead
    base_eff = (rn == PC_REG_NUM) ? INSTR_ADDR + PC_AHEAD : BASE_VAL;
    // RULE5: immediate-count shift
    // RULE10: left shift scales index
    offset = immf ? shift_imm(INDEX_VAL, INSTR[STYPE_HI:STYPE_LO],
                              INSTR[SHAMT_HI:SHAMT_LO], FLAGS[FL_C])
                  : {20'h0_0000, INSTR[OFS_HI:OFS_LO]};
    // RULE17: up adds, down subtracts
    sum  = up ? base_eff + offset : base_eff - offset;
    // RULE12: condition gate
    exec = ISSUE && is_sdt && cond_ok(INSTR[COND_HI:COND_LO], FLAGS);
  end

  // next-state logic
  always_comb begin
    d = q;
    d.rupd.base_we = 1'b0;  // write-back is a one-cycle pulse
    d.rupd.dest_we = 1'b0;
    case (q.st)
      LSAG_IDLE: begin
        if (exec) begin
          d.st           = LSAG_MEM;
          d.mreq.valid   = 1'b1;
          d.mreq.write   = !ld;
          // RULE3: byte or word size
          d.mreq.byte_sz = bsz;
          // RULE1: post-index with flag is user
          d.mreq.user    = !pre && wb;
          // RULE8: post uses old base
          // RULE7: pre uses the sum
          // RULE9: pre-index reads base +/- offset
          d.mreq.addr    = pre ? sum : base_eff;
          // RULE16: byte store replicated
          d.mreq.wdata   = bsz ? {4{SRC_VAL[7:0]}} : SRC_VAL;
          d.lane         = pre ? sum[1:0] : base_eff[1:0];
          d.rupd.base_num = rn;
          d.rupd.base_val = sum;
          d.rupd.dest_num = rd;
        end
      end
      LSAG_MEM: begin
        if (MEM_DONE) begin
          d.st         = LSAG_IDLE;
          d.mreq.valid = 1'b0;
          // RULE6: flag writes address back
          // RULE15: post writes back unless the base is pc
          // RULE4: pc base never written back
          d.rupd.base_we = (wb_q || !pre_q) &&
                           (q.rupd.base_num != PC_REG_NUM);
          if (!q.mreq.write) begin
            d.rupd.dest_we  = 1'b1;
            // RULE11: byte zero-extended
            d.rupd.dest_val = q.mreq.byte_sz
              ? {24'h00_0000, lane_of(MEM_RDATA, q.lane)}
              : MEM_RDATA;
          end
        end
      end
      default: d.st = LSAG_IDLE;
    endcase
  end

  // capture write-back intent at issue
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wb_q  <= 1'b0;
      pre_q <= 1'b0;
    end else if (exec && q.st == LSAG_IDLE) begin
      wb_q  <= wb;
      pre_q <= pre;
    end
  end

  // state register
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      q    <= '0;
      q.st <= LSAG_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs from the state register
  assign BUSY      = q.st == LSAG_MEM;
  assign MEM_REQ   = q.mreq.valid;
  assign MEM_WRITE = q.mreq.write;
  assign MEM_BYTE  = q.mreq.byte_sz;
  assign MEM_USER  = q.mreq.user;
  assign MEM_ADDR  = q.mreq.addr;
  assign MEM_WDATA = q.mreq.wdata;
  assign BASE_WE   = q.rupd.base_we;
  assign BASE_NUM  = q.rupd.base_num;
  assign BASE_NEW  = q.rupd.base_val;
  assign DEST_WE   = q.rupd.dest_we;
  assign DEST_NUM  = q.rupd.dest_num;
  assign DEST_DATA = q.rupd.dest_val;

  // RULE1: post-index flag gives user access
  user_post_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (q.st == LSAG_IDLE && exec && !pre && wb) |=> MEM_USER)
    else $error("post-index with flag not user");
  // RULE3: byte size follows bit
  size_sel_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (q.st == LSAG_IDLE && exec) |=> MEM_BYTE == $past(bsz))
    else $error("transfer size wrong");
  // RULE12: no request without condition
  cond_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (q.st == LSAG_IDLE && !exec) |=> !MEM_REQ)
    else $error("request without condition");
  // RULE8: post-index addresses old base
  post_addr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (q.st == LSAG_IDLE && exec && !pre) |=> MEM_ADDR == $past(base_eff))
    else $error("post-index address wrong");
  // RULE7: pre-index addresses the sum
  pre_addr_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (q.st == LSAG_IDLE && exec && pre) |=> MEM_ADDR == $past(sum))
    else $error("pre-index address wrong");
  // RULE16: byte store replicated
  byte_rep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (MEM_REQ && MEM_WRITE && MEM_BYTE) |->
      MEM_WDATA == {4{MEM_WDATA[7:0]}})
    else $error("byte store not replicated");
  // RULE11: byte load zero extended
  byte_zx_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (DEST_WE && $past(MEM_BYTE)) |-> DEST_DATA[31:8] == 24'h00_0000)
    else $error("byte load not zero extended");
  // RULE15: post-index writes back on completion
  post_wb_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUSY && MEM_DONE && !pre_q && BASE_NUM != PC_REG_NUM) |=> BASE_WE)
    else $error("post-index base not written");
  // RULE9: pre-index without flag keeps base
  pre_keep_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUSY && MEM_DONE && pre_q && !wb_q) |=> !BASE_WE)
    else $error("base written without flag");
endmodule : lsag_core

// file: lsag_core_test.sv
// self-checking bench for the load/store address generation block
`timescale 1ns/100ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
  n_mismatch++; $display("Error t=%0t got %h exp %h", $time, g, x); end end
module lsag_core_test;
  import lsag_pkg::*;
  typedef struct packed {
    lsag_mreq_t m;
    lsag_rupd_t r;
  } lsag_exp_t;
  logic sys_clk, rst, issue, busy, mem_req, mem_write, mem_byte, mem_user;
  logic mem_done, base_we, dest_we;
  logic [31:0] instr, instr_addr, base_val, index_val, src_val, mem_rdata;
  logic [31:0] mem_addr, mem_wdata, base_new, dest_data, rnd_q;
  logic [3:0]  flags, base_num, dest_num;
  logic [2:0]  wait_n;       // memory latency for the next transfer
  lsag_exp_t   exp_q[$];     // expected transfers, oldest first
  int          n_mismatch, samples_checked;

  lsag_core u_dut (.SYS_CLK(sys_clk), .RST(rst), .ISSUE(issue),
    .INSTR(instr), .INSTR_ADDR(instr_addr), .FLAGS(flags),
    .BASE_VAL(base_val), .INDEX_VAL(index_val), .SRC_VAL(src_val),
    .MEM_DONE(mem_done), .MEM_RDATA(mem_rdata), .BUSY(busy),
    .MEM_REQ(mem_req), .MEM_WRITE(mem_write), .MEM_BYTE(mem_byte),
    .MEM_USER(mem_user), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .BASE_WE(base_we), .BASE_NUM(base_num), .BASE_NEW(base_new),
    .DEST_WE(dest_we), .DEST_NUM(dest_num), .DEST_DATA(dest_data));
  lsag_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req),
    .mem_addr(mem_addr), .wait_n(wait_n), .mem_done(mem_done),
    .mem_rdata(mem_rdata));

  // 250 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // fixed-seed xorshift so every run is the same
  function automatic logic [31:0] xs();
    rnd_q ^= rnd_q << 13;
    rnd_q ^= rnd_q >> 17;
    rnd_q ^= rnd_q << 5;
    return rnd_q;
  endfunction : xs

  // barrel shift by an immediate amount, amount 0 only for left shift
  function automatic logic [31:0] shf(logic [31:0] v, logic [1:0] t,
                                      logic [4:0] a);
    case (t)
      SH_LSL: return v << a;
      SH_LSR: return v >> a;
      SH_ASR: return $signed(v) >>> a;
      default: return (v >> a) | (v << (6'd32 - a));
    endcase
  endfunction : shf

  // condition test against N Z C V
  function automatic logic cond_ok(logic [3:0] c, logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[FL_Z];
      3'h1: r = f[FL_C];
      3'h2: r = f[FL_N];
      3'h3: r = f[FL_V];
      3'h4: r = f[FL_C] & !f[FL_Z];
      3'h5: r = f[FL_N] == f[FL_V];
      3'h6: r = !f[FL_Z] & (f[FL_N] == f[FL_V]);
      default: r = 1'b1;
    endcase
    return c[0] ? !r : r;
  endfunction : cond_ok

  // one random instruction; called at a rising edge
  task automatic run_one();
    logic [31:0] r, r2, ia, bv, iv, sv, base, ofs, w, rw, ins;
    logic [3:0]  rn, cnd;
    logic [1:0]  ln;
    logic [4:0]  sa;
    logic        p, wb, im, tk;
    lsag_exp_t   e;
    int          n;
    r = xs();
    r2 = xs();
    ia = xs();
    bv = xs();
    iv = xs();
    sv = xs();
    rn = r[3:0];
    p = r[8];
    wb = r[11];
    im = r[13];
    sa = r[20:16];
    cnd = 4'(r[31:24] % 15);
    // avoid the special zero-amount forms of right shifts
    if (r[15:14] != SH_LSL && sa == 5'h0) sa = 5'h1;
    if (rn == PC_REG_NUM) begin
      p = 1'b1;
      wb = 1'b0;
    end
    ins = {cnd, (r[23:22] == 2'h0) ? 2'h3 : CLASS_SDT, im, p, r[9], r[10],
           wb, r[12], rn, r[7:4], im ? {sa, r[15:14], 1'b0, r2[3:0]}
                                     : r2[31:20]};
    issue <= 1'b1;
    instr <= ins;
    instr_addr <= ia;
    flags <= r2[7:4];
    base_val <= bv;
    index_val <= iv;
    src_val <= sv;
    wait_n <= r2[10:8];
    base = (rn == PC_REG_NUM) ? ia + PC_AHEAD : bv;
    ofs = im ? shf(iv, r[15:14], sa) : {20'h0_0000, ins[11:0]};
    w = r[9] ? base + ofs : base - ofs;
    e.m = {1'b1, !r[12], r[10], !p & wb, p ? w : base,
           r[10] ? {4{sv[7:0]}} : sv};
    ln = e.m.addr[1:0];
    rw = e.m.addr ^ 32'h5A3C_96E1;
    // word loads take the bus word as it stands, no lane rotation
    rw = r[10] ? {24'h00_0000, rw[8*ln +: 8]} : rw;
    e.r = {(wb | !p) & (rn != PC_REG_NUM), rn, w, r[12], r[7:4], rw};
    tk = ins[27:26] == CLASS_SDT && cond_ok(cnd, r2[7:4]);
    if (tk) exp_q.push_back(e);
    @(posedge sys_clk);
    issue <= r[21];
    @(posedge sys_clk);
    issue <= 1'b0;
    if (!tk) `CHK(busy, 1'b0)
    n = 0;
    // always let one edge pass so the next issue is not driven twice
    do begin
      @(posedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 40);
    if (n >= 40) n_mismatch++;
  endtask : run_one

  // at each completion compare the oldest note with the outputs
  always @(posedge sys_clk) begin
    if (!rst && mem_req === 1'b1 && mem_done === 1'b1) begin
      if (exp_q.size() == 0) `CHK(mem_addr, 32'h0000_0000)
      else begin
        lsag_exp_t e;
        e = exp_q.pop_front();
        `CHK(mem_addr, e.m.addr)
        `CHK(mem_user, e.m.user)
        `CHK(mem_byte, e.m.byte_sz)
        if (e.m.write) `CHK(mem_wdata, e.m.wdata)
        @(posedge sys_clk);
        `CHK(base_we, e.r.base_we)
        if (e.r.base_we) `CHK(base_new, e.r.base_val)
        `CHK(dest_we, e.r.dest_we)
        if (e.r.dest_we) `CHK(dest_data, e.r.dest_val)
      end
    end
  end

  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // main sequence: reset, then random instructions
  initial begin
    {issue, instr, instr_addr, flags, base_val, index_val} = '0;
    {src_val, wait_n, n_mismatch, samples_checked} = '0;
    rnd_q = 32'd48;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (400) run_one();
    repeat (4) @(posedge sys_clk);
    report_and_stop();
  end

  // hang guard, far beyond 400 transfers of at most a dozen cycles
  initial begin
    #80000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : lsag_core_test

// file: lsag_mem_model.sv
// memory partner model on the data bus side of the block
`timescale 1ns/100ps
module lsag_mem_model
  import lsag_pkg::*;
(
  input  wire logic        sys_clk,   // core clock
  input  wire logic        rst,       // asynchronous reset, high
  input  wire logic        mem_req,   // request from the block
  input  wire logic [31:0] mem_addr,  // transfer address
  input  wire logic [2:0]  wait_n,    // wait cycles before completion
  output logic             mem_done,  // one-cycle completion pulse
  output logic [31:0]      mem_rdata  // load data, valid only with done
);
  logic [2:0]  cnt_q;   // wait cycles spent on this request
  logic [31:0] junk_q;  // filler, changes every cycle so stale data fails

  // answer after wait_n cycles; done drops at once so req can fall
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'h0;
      mem_done <= 1'b0;
      junk_q <= 32'h0000_0001;
    end else begin
      junk_q <= junk_q + 32'h9E37_79B9;
      if (mem_req && !mem_done && cnt_q == wait_n) begin
        mem_done <= 1'b1;
        cnt_q <= 3'h0;
      end else begin
        mem_done <= 1'b0;
        // count only while a request really waits
        if (mem_req && !mem_done) begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end

  // the word is a simple scramble of the address, so the bench can predict
  assign mem_rdata = mem_done ? (mem_addr ^ 32'h5A3C_96E1) : junk_q;
endmodule : lsag_mem_model

// file: lsag_pkg.sv
// package for the load/store address generation block
package lsag_pkg;
  // instruction field positions
  localparam int COND_HI     = 31;
  localparam int COND_LO     = 28;
  localparam int CLASS_HI    = 27;
  localparam int CLASS_LO    = 26;
  localparam int IMM_BIT     = 25;
  localparam int PRE_BIT     = 24;
  localparam int UP_BIT      = 23;
  localparam int BYTE_BIT    = 22;
  localparam int WB_BIT      = 21;
  localparam int LOAD_BIT    = 20;
  localparam int RN_HI       = 19;
  localparam int RN_LO       = 16;
  localparam int RD_HI       = 15;
  localparam int RD_LO       = 12;
  localparam int OFS_HI      = 11;
  localparam int OFS_LO      = 0;
  localparam int SHAMT_HI    = 11;
  localparam int SHAMT_LO    = 7;
  localparam int STYPE_HI    = 6;
  localparam int STYPE_LO    = 5;
  localparam int SREG_BIT    = 4;
  localparam int RM_HI       = 3;
  localparam int RM_LO       = 0;
  // class code of single data transfer
  localparam logic [1:0] CLASS_SDT = 2'h1;
  // program counter register number and read-ahead
  localparam logic [3:0]  PC_REG_NUM  = 4'hF;
  localparam logic [31:0] PC_AHEAD    = 32'h0000_0008;
  // shift types
  localparam logic [1:0] SH_LSL = 2'h0;
  localparam logic [1:0] SH_LSR = 2'h1;
  localparam logic [1:0] SH_ASR = 2'h2;
  localparam logic [1:0] SH_ROR = 2'h3;
  // condition codes
  localparam logic [3:0] CC_EQ = 4'h0;
  localparam logic [3:0] CC_NE = 4'h1;
  localparam logic [3:0] CC_CS = 4'h2;
  localparam logic [3:0] CC_CC = 4'h3;
  localparam logic [3:0] CC_MI = 4'h4;
  localparam logic [3:0] CC_PL = 4'h5;
  localparam logic [3:0] CC_VS = 4'h6;
  localparam logic [3:0] CC_VC = 4'h7;
  localparam logic [3:0] CC_HI = 4'h8;
  localparam logic [3:0] CC_LS = 4'h9;
  localparam logic [3:0] CC_GE = 4'hA;
  localparam logic [3:0] CC_LT = 4'hB;
  localparam logic [3:0] CC_GT = 4'hC;
  localparam logic [3:0] CC_LE = 4'hD;
  localparam logic [3:0] CC_AL = 4'hE;
  // flag positions in the NZCV nibble
  localparam int FL_N = 3;
  localparam int FL_Z = 2;
  localparam int FL_C = 1;
  localparam int FL_V = 0;
  // byte lane width
  localparam int BYTE_W = 8;

  // issue phases, one-hot
  typedef enum logic [1:0] {
    LSAG_IDLE = 2'b01,
    LSAG_MEM  = 2'b10
  } lsag_st_t;

  // memory request produced for one transfer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        byte_sz;
    logic        user;
    logic [31:0] addr;
    logic [31:0] wdata;
  } lsag_mreq_t;

  // register-file update produced for one transfer
  typedef struct packed {
    logic        base_we;
    logic [3:0]  base_num;
    logic [31:0] base_val;
    logic        dest_we;
    logic [3:0]  dest_num;
    logic [31:0] dest_val;
  } lsag_rupd_t;

  // state of the block apart from wb_q and pre_q
  typedef struct packed {
    lsag_st_t    st;
    lsag_mreq_t  mreq;
    lsag_rupd_t  rupd;
    logic [1:0]  lane;
  } lsag_state_t;
endpackage : lsag_pkg
